/* src/dag_top.sv */
// What this block does
// - Two independent address units, X and Y
// - Y unit serves word reads, MAC only
// - Linear, circular and bit-reversed addressing
// - Linear and circular for data or program
// - Bit reversal only for data space
// - 13-bit field selects near data space
// - File-register ops imply working register zero
// - Result to file register or implied reg
// - File-register move reaches whole data space
// - First operand is register direct only
// - Second operand register, memory or 5-bit
// - Result to working register or memory
// - Arithmetic modes incl. 5/10-bit literals
// - File direct takes address from instruction
// - Register direct does no memory access
// - Indirect uses pointer unchanged
// - Post-modify: use pointer, then step
// - Pre-modify: step pointer, then use
// - Register offset: pointer plus base register
// - Literal offset: pointer plus literal
// - X circular needs enable and select not 15
// - Y circular needs enable and select not 15
// - Bit reverse needs enable, select, increment
// - Write back corrected pointer only on modify
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dag_consts.svh"
module dag_top
  import dag_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input  wire logic            CLK_SYS,
  input  wire logic            RST_B,
  // Avalon-MM register slave
  input  wire logic [15:0]     AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [31:0]     AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output logic [31:0]          AVS_READDATA,
  output logic                 AVS_WAITREQUEST,
  output logic [1:0]           AVS_RESPONSE,
  // X unit request
  input  wire logic            X_REQ,
  input  wire dag_mode_t       X_MODE,
  input  wire logic [3:0]      X_PTR_SEL,
  input  wire logic [AW-1:0]   X_PTR_VAL,
  input  wire logic [AW-1:0]   X_OFS_VAL,
  input  wire logic            X_PROG_SPACE,
  input  wire logic            X_MOVE_FILE,
  input  wire logic            X_IS_WRITE,
  // Y unit request
  input  wire logic            Y_REQ,
  input  wire dag_mode_t       Y_MODE,
  input  wire logic [3:0]      Y_PTR_SEL,
  input  wire logic [AW-1:0]   Y_PTR_VAL,
  input  wire logic [AW-1:0]   Y_OFS_VAL,
  input  wire logic            Y_IS_MAC,
  input  wire logic            Y_IS_WRITE,
  // Three-operand operand 2 source
  input  wire dag_src_t        OP2_SRC,
  input  wire logic [4:0]      OP2_LIT,
  input  wire logic            LIT10_SEL,
  input  wire logic [9:0]      LIT10,
  // X unit result
  output logic                 X_VALID,
  output logic [AW-1:0]        X_EA,
  output logic                 X_MEM_ACCESS,
  output logic                 X_WB_EN,
  output logic [3:0]           X_WB_SEL,
  output logic [AW-1:0]        X_WB_VAL,
  output logic                 X_IMPLIED_W0,
  // Y unit result
  output logic                 Y_VALID,
  output logic [AW-1:0]        Y_EA,
  output logic                 Y_MEM_ACCESS,
  output logic                 Y_WB_EN,
  output logic [3:0]           Y_WB_SEL,
  output logic [AW-1:0]        Y_WB_VAL,
  output logic                 Y_REFUSED,
  // Literal operand result
  output logic [AW-1:0]        LIT_VAL,
  output logic                 LIT_VALID
);

  typedef struct packed {
    logic [15:0]   mode;
    logic [15:0]   xs;
    logic [15:0]   xe;
    logic [15:0]   ys;
    logic [15:0]   ye;
    logic [15:0]   brev;
    dag_bus_t      bus;
    logic [31:0]   rdata;
    logic [1:0]    resp;
    logic          wreq;
    logic          xv;
    logic [AW-1:0] xea;
    logic          xmem;
    logic          xwb;
    logic [3:0]    xwbs;
    logic [AW-1:0] xwbv;
    logic          xw0;
    logic          yv;
    logic [AW-1:0] yea;
    logic          ymem;
    logic          ywb;
    logic [3:0]    ywbs;
    logic [AW-1:0] ywbv;
    logic          yref;
    logic [AW-1:0] lit;
    logic          litv;
  } dag_state_t;

  dag_state_t st_r;
  dag_state_t st_nxt;

  // Reverse bit order of a modifier
  function automatic logic [AW-1:0] rev_mod(input logic [AW-1:0] m);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < AW; i++) begin
      r[i] = m[AW-1-i];
    end
    return r;
  endfunction

  // Reverse-carry add: reversal of (rev(a) + rev(b))
  function automatic logic [AW-1:0] rev_add(input logic [AW-1:0] a,
                                            input logic [AW-1:0] b);
    logic [AW-1:0] s;
    s = rev_mod(a) + rev_mod(b);
    return rev_mod(s);
  endfunction

  // Wrap an address into [s, e] by buffer length
  function automatic logic [AW-1:0] circ(input logic [AW-1:0] a,
                                         input logic [15:0] s,
                                         input logic [15:0] e);
    logic [AW-1:0] len;
    len = AW'(e) - AW'(s) + AW'(1);
    if (a > AW'(e)) begin
      circ = a - len;
    end else if (a < AW'(s)) begin
      circ = a + len;
    end else begin
      circ = a;
    end
  endfunction

  function automatic logic bus_hit(input logic [15:0] a);
    bus_hit = (a == `DAG_OFS_MODE) || (a == `DAG_OFS_XSTART) ||
              (a == `DAG_OFS_XEND) || (a == `DAG_OFS_YSTART) ||
              (a == `DAG_OFS_YEND) || (a == `DAG_OFS_BREV);
  endfunction

  logic          x_circ_on;
  logic          y_circ_on;
  logic          brev_on;
  logic [AW-1:0] x_raw;
  logic [AW-1:0] x_ptr_new;
  logic [AW-1:0] y_raw;
  logic [AW-1:0] y_ptr_new;
  logic [15:0]   wval;

  always_comb begin
    st_nxt     = st_r;
    x_circ_on  = 1'b0;
    y_circ_on  = 1'b0;
    brev_on    = 1'b0;
    x_raw      = X_PTR_VAL;
    x_ptr_new  = X_PTR_VAL;
    y_raw      = Y_PTR_VAL;
    y_ptr_new  = Y_PTR_VAL;
    wval       = AVS_WRITEDATA[15:0];
    if (!AVS_BYTEENABLE[0]) begin
      wval[7:0] = 8'h00;
    end
    if (!AVS_BYTEENABLE[1]) begin
      wval[15:8] = 8'h00;
    end

    // Bus: one wait cycle, then answer
    case (st_r.bus)
      DAG_BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_nxt.bus   = DAG_BUS_ACK;
          st_nxt.wreq  = 1'b0;
          st_nxt.resp  = bus_hit(AVS_ADDRESS) ? 2'h0 : 2'h3;
          st_nxt.rdata = 32'h0000_0000;
          if (AVS_READ) begin
            case (AVS_ADDRESS)
              `DAG_OFS_MODE:   st_nxt.rdata[15:0] = st_r.mode;
              `DAG_OFS_XSTART: st_nxt.rdata[15:0] = st_r.xs;
              `DAG_OFS_XEND:   st_nxt.rdata[15:0] = st_r.xe;
              `DAG_OFS_YSTART: st_nxt.rdata[15:0] = st_r.ys;
              `DAG_OFS_YEND:   st_nxt.rdata[15:0] = st_r.ye;
              `DAG_OFS_BREV:   st_nxt.rdata[15:0] = st_r.brev;
              default:         st_nxt.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      DAG_BUS_ACK: begin
        st_nxt.bus  = DAG_BUS_IDLE;
        st_nxt.wreq = 1'b1;
        // Write lands only at the edge that ends the answer cycle, one cycle after the wait
        if (AVS_WRITE) begin
          // Unwritten byte lanes keep their old value
          case (AVS_ADDRESS)
            `DAG_OFS_MODE: begin
              st_nxt.mode = (st_r.mode & ~{{8{AVS_BYTEENABLE[1]}},
                             {8{AVS_BYTEENABLE[0]}}}) | wval;
            end
            `DAG_OFS_XSTART: begin
              st_nxt.xs = ((st_r.xs & ~{{8{AVS_BYTEENABLE[1]}},
                           {8{AVS_BYTEENABLE[0]}}}) | wval) & 16'hFFFE;
            end
            `DAG_OFS_XEND: begin
              st_nxt.xe = ((st_r.xe & ~{{8{AVS_BYTEENABLE[1]}},
                           {8{AVS_BYTEENABLE[0]}}}) | wval) | 16'h0001;
            end
            `DAG_OFS_YSTART: begin
              st_nxt.ys = ((st_r.ys & ~{{8{AVS_BYTEENABLE[1]}},
                           {8{AVS_BYTEENABLE[0]}}}) | wval) & 16'hFFFE;
            end
            `DAG_OFS_YEND: begin
              st_nxt.ye = ((st_r.ye & ~{{8{AVS_BYTEENABLE[1]}},
                           {8{AVS_BYTEENABLE[0]}}}) | wval) | 16'h0001;
            end
            `DAG_OFS_BREV: begin
              st_nxt.brev = (st_r.brev & ~{{8{AVS_BYTEENABLE[1]}},
                             {8{AVS_BYTEENABLE[0]}}}) | wval;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        st_nxt.bus  = DAG_BUS_IDLE;
        st_nxt.wreq = 1'b1;
      end
    endcase

    x_circ_on = st_r.mode[`DAG_XEN_BIT] &&
                (st_r.mode[`DAG_XSEL_LSB+:4] != `DAG_SEL_OFF) &&
                (st_r.mode[`DAG_XSEL_LSB+:4] == X_PTR_SEL);
    y_circ_on = st_r.mode[`DAG_YEN_BIT] &&
                (st_r.mode[`DAG_YSEL_LSB+:4] != `DAG_SEL_OFF) &&
                (st_r.mode[`DAG_YSEL_LSB+:4] == Y_PTR_SEL);
    // bit reverse gating, data writes only
    brev_on = st_r.brev[`DAG_BITREV_ENABLE_BIT] &&
              (st_r.mode[`DAG_BSEL_LSB+:4] != `DAG_SEL_OFF) &&
              (st_r.mode[`DAG_BSEL_LSB+:4] == X_PTR_SEL) &&
              !X_PROG_SPACE && X_IS_WRITE &&
              ((X_MODE == DAG_AM_PRE) || (X_MODE == DAG_AM_POST)) &&
              !X_OFS_VAL[AW-1];

    // X unit computes independently of Y
    case (X_MODE)
      DAG_AM_FILE: x_raw = X_MOVE_FILE ? X_OFS_VAL :
                           AW'(X_OFS_VAL[`DAG_NEAR_BITS-1:0]);
      DAG_AM_IND:  x_raw = X_PTR_VAL;
      DAG_AM_POST: begin
        x_raw     = X_PTR_VAL;
        x_ptr_new = brev_on ? rev_add(X_PTR_VAL,
                              {1'b0, st_r.brev[AW-2:0]}) : X_PTR_VAL + X_OFS_VAL;
      end
      DAG_AM_PRE: begin
        x_raw     = brev_on ? rev_add(X_PTR_VAL,
                              {1'b0, st_r.brev[AW-2:0]}) : X_PTR_VAL + X_OFS_VAL;
        x_ptr_new = x_raw;
      end
      DAG_AM_ROFS, DAG_AM_LOFS: x_raw = X_PTR_VAL + X_OFS_VAL;
      default:     x_raw = X_PTR_VAL;
    endcase
    if (x_circ_on && !brev_on && X_MODE != DAG_AM_FILE && X_MODE != DAG_AM_REG) begin
      x_raw     = circ(x_raw, st_r.xs, st_r.xe);
      x_ptr_new = circ(x_ptr_new, st_r.xs, st_r.xe);
    end

    case (Y_MODE)
      DAG_AM_IND:  y_raw = Y_PTR_VAL;
      DAG_AM_POST: y_ptr_new = Y_PTR_VAL + Y_OFS_VAL;
      DAG_AM_PRE: begin
        y_raw     = Y_PTR_VAL + Y_OFS_VAL;
        y_ptr_new = y_raw;
      end
      DAG_AM_ROFS: y_raw = Y_PTR_VAL + Y_OFS_VAL;
      default:     y_raw = Y_PTR_VAL;
    endcase
    if (y_circ_on) begin
      y_raw     = circ(y_raw, st_r.ys, st_r.ye);
      y_ptr_new = circ(y_ptr_new, st_r.ys, st_r.ye);
    end

    st_nxt.xv   = X_REQ;
    st_nxt.xea  = x_raw;
    // register direct makes no memory access
    st_nxt.xmem = X_REQ && (X_MODE != DAG_AM_REG);
    st_nxt.xwb  = X_REQ && ((X_MODE == DAG_AM_POST) || (X_MODE == DAG_AM_PRE));
    st_nxt.xwbs = X_PTR_SEL;
    st_nxt.xwbv = x_ptr_new;
    st_nxt.xw0  = X_REQ && (X_MODE == DAG_AM_FILE);

    // Y serves only MAC word reads
    st_nxt.yref = Y_REQ && (!Y_IS_MAC || Y_IS_WRITE || (Y_MODE == DAG_AM_FILE) ||
                  (Y_MODE == DAG_AM_REG) || (Y_MODE == DAG_AM_LOFS));
    st_nxt.yv   = Y_REQ && !st_nxt.yref;
    st_nxt.yea  = {y_raw[AW-1:1], 1'b0};
    st_nxt.ymem = st_nxt.yv;
    st_nxt.ywb  = st_nxt.yv && ((Y_MODE == DAG_AM_POST) || (Y_MODE == DAG_AM_PRE));
    st_nxt.ywbs = Y_PTR_SEL;
    st_nxt.ywbv = {y_ptr_new[AW-1:1], 1'b0};

    st_nxt.litv = X_REQ && (OP2_SRC == DAG_SRC_LIT);
    st_nxt.lit  = LIT10_SEL ? AW'(LIT10) : AW'(OP2_LIT);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r       <= '0;
      st_r.mode  <= `DAG_MODE_RST;
      st_r.xs    <= `DAG_START_RST;
      st_r.xe    <= `DAG_END_RST;
      st_r.ys    <= `DAG_START_RST;
      st_r.ye    <= `DAG_END_RST;
      st_r.brev  <= `DAG_BREV_RST;
      st_r.bus   <= DAG_BUS_IDLE;
      st_r.wreq  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AVS_READDATA    = st_r.rdata;
  assign AVS_WAITREQUEST = st_r.wreq;
  assign AVS_RESPONSE    = st_r.resp;
  assign X_VALID         = st_r.xv;
  assign X_EA            = st_r.xea;
  assign X_MEM_ACCESS    = st_r.xmem;
  assign X_WB_EN         = st_r.xwb;
  assign X_WB_SEL        = st_r.xwbs;
  assign X_WB_VAL        = st_r.xwbv;
  assign X_IMPLIED_W0    = st_r.xw0;
  assign Y_VALID         = st_r.yv;
  assign Y_EA            = st_r.yea;
  assign Y_MEM_ACCESS    = st_r.ymem;
  assign Y_WB_EN         = st_r.ywb;
  assign Y_WB_SEL        = st_r.ywbs;
  assign Y_WB_VAL        = st_r.ywbv;
  assign Y_REFUSED       = st_r.yref;
  assign LIT_VAL         = st_r.lit;
  assign LIT_VALID       = st_r.litv;

endmodule

/* src/dag_consts.svh */
`ifndef DAG_CONSTS_SVH
`define DAG_CONSTS_SVH
// Register byte offsets on the bus
`define DAG_OFS_MODE      16'h0046
`define DAG_OFS_XSTART    16'h0048
`define DAG_OFS_XEND      16'h004A
`define DAG_OFS_YSTART    16'h004C
`define DAG_OFS_YEND      16'h004E
`define DAG_OFS_BREV      16'h0050
// Mode control fields and bit-reverse enable bit
`define DAG_XEN_BIT       15
`define DAG_YEN_BIT       14
`define DAG_BSEL_LSB      8
`define DAG_YSEL_LSB      4
`define DAG_XSEL_LSB      0
`define DAG_SEL_OFF       4'hF
`define DAG_BITREV_ENABLE_BIT      15
// Reset values
`define DAG_MODE_RST      16'h0000
`define DAG_START_RST     16'h0000
`define DAG_END_RST       16'h0001
`define DAG_BREV_RST      16'h0000
// Near data space: 13-bit field, 8192 bytes
`define DAG_NEAR_BITS     13
`endif

/* src/dag_pkg.sv */
package dag_pkg;
  typedef enum logic [2:0] {
    DAG_AM_FILE,
    DAG_AM_REG,
    DAG_AM_IND,
    DAG_AM_POST,
    DAG_AM_PRE,
    DAG_AM_ROFS,
    DAG_AM_LOFS
  } dag_mode_t;
  typedef enum logic [1:0] {
    DAG_SRC_REG,
    DAG_SRC_MEM,
    DAG_SRC_LIT
  } dag_src_t;
  typedef enum logic [1:0] {
    DAG_BUS_IDLE,
    DAG_BUS_ACK
  } dag_bus_t;
endpackage

/* tb/dag_top_assertions.sv */
`timescale 1ns/1ps
module dag_top_assertions
  import dag_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic          CLK_SYS,
  input wire logic          RST_B,
  // Bus
  input wire logic          AVS_READ,
  input wire logic          AVS_WRITE,
  input wire logic          AVS_WAITREQUEST,
  // X unit
  input wire logic          X_REQ,
  input wire dag_mode_t     X_MODE,
  input wire logic [3:0]    X_PTR_SEL,
  input wire logic [AW-1:0] X_PTR_VAL,
  input wire logic [AW-1:0] X_OFS_VAL,
  input wire logic          X_MOVE_FILE,
  input wire logic          X_VALID,
  input wire logic [AW-1:0] X_EA,
  input wire logic          X_MEM_ACCESS,
  input wire logic          X_WB_EN,
  input wire logic [AW-1:0] X_WB_VAL,
  input wire logic          X_IMPLIED_W0,
  // Y unit
  input wire logic          Y_REQ,
  input wire logic          Y_IS_MAC,
  input wire logic          Y_VALID,
  input wire logic          Y_REFUSED
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Select 15 keeps circular and bit reverse out of the picture
  logic lin;
  assign lin = X_REQ && X_PTR_SEL == 4'hF;

  x_answer_a: assert property (X_REQ |=> X_VALID)
    else $error("x unit gave no answer");
  y_answer_a: assert property (Y_REQ |=> Y_VALID != Y_REFUSED)
    else $error("y unit gave no answer");
  reg_direct_a: assert property (X_REQ && X_MODE == DAG_AM_REG |=> !X_MEM_ACCESS)
    else $error("register direct touched memory");
  ind_plain_a: assert property (lin && X_MODE == DAG_AM_IND |=>
    X_EA == $past(X_PTR_VAL) && !X_WB_EN)
    else $error("indirect address not the pointer");
  post_step_a: assert property (lin && X_MODE == DAG_AM_POST |=>
    X_EA == $past(X_PTR_VAL) && X_WB_EN && X_WB_VAL == $past(X_PTR_VAL) + $past(X_OFS_VAL))
    else $error("post modify wrong");
  pre_step_a: assert property (lin && X_MODE == DAG_AM_PRE |=>
    X_WB_EN && X_EA == X_WB_VAL && X_EA == $past(X_PTR_VAL) + $past(X_OFS_VAL))
    else $error("pre modify wrong");
  offset_sum_a: assert property (lin &&
    (X_MODE == DAG_AM_ROFS || X_MODE == DAG_AM_LOFS) |=>
    !X_WB_EN && X_EA == $past(X_PTR_VAL) + $past(X_OFS_VAL))
    else $error("offset address wrong");
  file_near_a: assert property (X_REQ && X_MODE == DAG_AM_FILE &&
    !X_MOVE_FILE |=> X_IMPLIED_W0 && X_EA == ($past(X_OFS_VAL) & 16'h1FFF))
    else $error("near file address wrong");
  file_move_a: assert property (X_REQ && X_MODE == DAG_AM_FILE && X_MOVE_FILE |=>
    X_EA == $past(X_OFS_VAL))
    else $error("file move address cut short");
  y_refuse_a: assert property (Y_REQ && !Y_IS_MAC |=> Y_REFUSED)
    else $error("y unit took a non mac request");
  bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus wait state too long");
endmodule
bind dag_top dag_top_assertions #(.AW(AW)) dag_top_assertions_inst (.*);

/* tb/dag_cpu_model.sv */
`timescale 1ns/1ps
module dag_cpu_model
  import dag_pkg::*;
(
  // Clock
  input  wire logic   CLK_SYS,
  // X request
  output logic        X_REQ,
  output dag_mode_t   X_MODE,
  output logic [3:0]  X_PTR_SEL,
  output logic [15:0] X_PTR_VAL,
  output logic [15:0] X_OFS_VAL,
  output logic        X_PROG_SPACE,
  output logic        X_MOVE_FILE,
  output logic        X_IS_WRITE,
  // Y request
  output logic        Y_REQ,
  output dag_mode_t   Y_MODE,
  output logic [3:0]  Y_PTR_SEL,
  output logic [15:0] Y_PTR_VAL,
  output logic [15:0] Y_OFS_VAL,
  output logic        Y_IS_MAC,
  output logic        Y_IS_WRITE,
  // Second operand
  output dag_src_t    OP2_SRC,
  output logic [4:0]  OP2_LIT,
  output logic        LIT10_SEL,
  output logic [9:0]  LIT10
);
  initial begin
    X_MODE = DAG_AM_IND;
    Y_MODE = DAG_AM_IND;
    OP2_SRC = DAG_SRC_REG;
    {X_REQ, X_PTR_SEL, X_PTR_VAL, X_OFS_VAL, X_PROG_SPACE, X_MOVE_FILE, X_IS_WRITE} = '0;
    {Y_REQ, Y_PTR_SEL, Y_PTR_VAL, Y_OFS_VAL, Y_IS_MAC, Y_IS_WRITE} = '0;
    {OP2_LIT, LIT10_SEL, LIT10} = '0;
  end
  // One instruction drives both units and the literal path
  task automatic go(input dag_mode_t xm, input logic [3:0] xs, input logic [15:0] xp,
                    input logic [15:0] xo, input logic [2:0] xf, input dag_mode_t ym,
                    input logic [15:0] yp, input logic [15:0] yo, input logic [1:0] yf,
                    input logic [17:0] l);
    @(posedge CLK_SYS);
    X_REQ <= 1'b1;
    X_MODE <= xm;
    X_PTR_SEL <= xs;
    X_PTR_VAL <= xp;
    X_OFS_VAL <= xo;
    {X_PROG_SPACE, X_MOVE_FILE, X_IS_WRITE} <= xf;
    Y_REQ <= 1'b1;
    Y_MODE <= ym;
    Y_PTR_SEL <= xs + 4'h1;
    Y_PTR_VAL <= yp;
    Y_OFS_VAL <= yo;
    {Y_IS_MAC, Y_IS_WRITE} <= yf;
    OP2_SRC <= dag_src_t'(l[17:16]);
    {OP2_LIT, LIT10_SEL, LIT10} <= l[15:0];
    @(posedge CLK_SYS);
    X_REQ <= 1'b0;
    Y_REQ <= 1'b0;
    // Stale operands must not pass for fresh ones
    X_PTR_VAL <= ~xp;
    X_OFS_VAL <= ~xo;
    Y_PTR_VAL <= ~yp;
    @(negedge CLK_SYS);
  endtask
endmodule

/* tb/dag_top_test.sv */
`timescale 1ns/1ps
module dag_top_test
  import dag_pkg::*;
;
  logic CLK_SYS = 1'b0;
  logic RST_B = 1'b0;
  logic [15:0] AVS_ADDRESS = 16'h0000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_READDATA;
  logic [1:0] AVS_RESPONSE;
  logic [15:0] X_PTR_VAL, X_OFS_VAL, Y_PTR_VAL, Y_OFS_VAL, X_EA, X_WB_VAL, Y_EA, Y_WB_VAL;
  logic [15:0] LIT_VAL;
  logic AVS_WAITREQUEST, X_REQ, X_PROG_SPACE, X_MOVE_FILE, X_IS_WRITE, Y_REQ, Y_IS_MAC;
  logic Y_IS_WRITE, LIT10_SEL, X_VALID, X_MEM_ACCESS, X_WB_EN, X_IMPLIED_W0, Y_VALID;
  logic Y_MEM_ACCESS, Y_WB_EN, Y_REFUSED, LIT_VALID;
  logic [3:0] X_PTR_SEL, Y_PTR_SEL, X_WB_SEL, Y_WB_SEL;
  logic [4:0] OP2_LIT;
  logic [9:0] LIT10;
  dag_mode_t X_MODE, Y_MODE, xm, ym;
  dag_src_t OP2_SRC;
  int miscompares = 0;
  int check_count = 0;
  logic [15:0] s = 16'h0031;
  logic [15:0] p, o;
  logic [17:0] l;
  logic yok;

  dag_top dag_top_inst (.*);
  dag_cpu_model dag_cpu_model_inst (.*);

  always #12.5 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] x_ea(input dag_mode_t m, input logic [15:0] a, b,
                                       input logic mv);
    case (m)
      DAG_AM_FILE: return mv ? b : {3'h0, b[12:0]};
      DAG_AM_IND, DAG_AM_POST: return a;
      default: return a + b;
    endcase
  endfunction

  task automatic close_out;
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic [1:0] r);
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_BYTEENABLE <= 4'h3;
    AVS_WRITEDATA <= {16'h0000, d};
    // Values read here are those sampled at the edge
    do begin
      @(posedge CLK_SYS);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA[15:0];
    r = AVS_RESPONSE;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [1:0] er);
    logic [15:0] q;
    logic [1:0] r;
    bus(1'b0, a, 16'h0000, q, r);
    chk(q, e);
    chk(r, er);
  endtask

  // Without a random write, the reset values are expected
  task automatic regs(input logic rnd);
    logic [15:0] a, e;
    for (int i = 0; i < 6; i++) begin
      a = 16'h0046 + 16'(2 * i);
      e = (i == 2 || i == 4) ? 16'h0001 : 16'h0000;
      if (rnd) begin
        s = nx(s);
        wr(a, s);
        e = (i == 1 || i == 3) ? s & 16'hFFFE : (i == 2 || i == 4) ? s | 16'h0001 : s;
      end
      rd(a, e, 2'b00);
    end
  endtask

  task automatic cx(input dag_mode_t m, input logic [3:0] sel, input logic [15:0] a, b,
                    input logic [2:0] f, input logic [15:0] ea, wb);
    dag_cpu_model_inst.go(m, sel, a, b, f, DAG_AM_IND, 16'h0000, 16'h0000, 2'b10, 18'h00000);
    chk(X_EA, ea);
    chk(X_WB_EN, m == DAG_AM_POST || m == DAG_AM_PRE);
    if (X_WB_EN === 1'b1) chk(X_WB_VAL, wb);
  endtask

  initial begin
    repeat (4000) @(posedge CLK_SYS);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    regs(1'b0);
    regs(1'b1);
    rd(16'h0060, 16'h0000, 2'b11);
    @(posedge CLK_SYS);
    RST_B <= 1'b0;
    @(posedge CLK_SYS);
    RST_B <= 1'b1;
    regs(1'b0);
    for (int i = 0; i < 60; i++) begin
      s = nx(s);
      p = nx(s);
      o = nx(p);
      xm = dag_mode_t'((s[2:0] == 3'h7) ? 3'h0 : s[2:0]);
      ym = dag_mode_t'((p[2:0] == 3'h7) ? 3'h2 : p[2:0]);
      l = {s[13], ~s[13] & s[14], o};
      dag_cpu_model_inst.go(xm, s[7:4], p, o, s[10:8], ym, o, p, {p[9] | p[10], p[11] & p[12]}, l);
      chk(X_VALID, 1'b1);
      yok = (p[9] | p[10]) && !(p[11] & p[12]) &&
            ym inside {DAG_AM_IND, DAG_AM_POST, DAG_AM_PRE, DAG_AM_ROFS};
      chk(Y_VALID, yok);
      if (xm != DAG_AM_REG) chk(X_EA, x_ea(xm, p, o, s[9]));
      chk(X_MEM_ACCESS, xm != DAG_AM_REG);
      chk(X_WB_EN, xm == DAG_AM_POST || xm == DAG_AM_PRE);
      if (X_WB_EN === 1'b1) chk(X_WB_VAL, x_ea(DAG_AM_PRE, p, o, 1'b0));
      chk(X_IMPLIED_W0, xm == DAG_AM_FILE);
      chk(Y_REFUSED, !yok);
      chk(Y_MEM_ACCESS, yok);
      if (yok)
        chk(Y_EA, ((ym inside {DAG_AM_IND, DAG_AM_POST}) ? o : o + p) & 16'hFFFE);
      chk(Y_WB_EN, yok && (ym inside {DAG_AM_POST, DAG_AM_PRE}));
      if (yok && (ym inside {DAG_AM_POST, DAG_AM_PRE}))
        chk(Y_WB_VAL, (o + p) & 16'hFFFE);
      chk(X_WB_SEL, s[7:4]);
      chk(Y_WB_SEL, 4'(s[7:4] + 4'h1));
      chk(LIT_VALID, l[17:16] == 2'b10);
      if (l[17:16] == 2'b10) chk(LIT_VAL, l[10] ? {6'h00, l[9:0]} : {11'h000, l[15:11]});
      s = o;
    end
    wr(16'h0046, 16'h8001);
    wr(16'h0048, 16'h1001);
    wr(16'h004A, 16'h100E);
    rd(16'h0048, 16'h1000, 2'b00);
    rd(16'h004A, 16'h100F, 2'b00);
    cx(DAG_AM_POST, 4'h1, 16'h100E, 16'h0002, 3'h0, 16'h100E, 16'h1000);
    cx(DAG_AM_PRE, 4'h1, 16'h1000, 16'hFFFE, 3'h0, 16'h100E, 16'h100E);
    cx(DAG_AM_LOFS, 4'h1, 16'h100E, 16'h0004, 3'h0, 16'h1002, 16'h0000);
    cx(DAG_AM_POST, 4'h2, 16'h100E, 16'h0002, 3'h0, 16'h100E, 16'h1010);
    cx(DAG_AM_POST, 4'h1, 16'h100E, 16'h0002, 3'h4, 16'h100E, 16'h1000);
    wr(16'h0046, 16'h800F);
    cx(DAG_AM_POST, 4'hF, 16'h100E, 16'h0002, 3'h0, 16'h100E, 16'h1010);
    wr(16'h0046, 16'h0001);
    cx(DAG_AM_POST, 4'h1, 16'h100E, 16'h0002, 3'h0, 16'h100E, 16'h1010);
    wr(16'h0046, 16'h0100);
    wr(16'h0050, 16'h8008);
    cx(DAG_AM_POST, 4'h1, 16'h1008, 16'h0002, 3'h1, 16'h1008, 16'h1004);
    cx(DAG_AM_POST, 4'h1, 16'h1008, 16'h0002, 3'h0, 16'h1008, 16'h100A);
    cx(DAG_AM_POST, 4'h1, 16'h1008, 16'h0002, 3'h5, 16'h1008, 16'h100A);
    cx(DAG_AM_POST, 4'h1, 16'h1008, 16'hFFFE, 3'h1, 16'h1008, 16'h1006);
    close_out();
  end
endmodule
